/* File: design/dspt_device.sv */
`timescale 1ns/1ps
module dspt_device #(
    parameter int STALL_CYC = dspt_pkg::STALL_CYC
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    dspt_link_if.dev link,
    input wire logic [23:0] i_rd_data,
    output logic o_wr_valid,
    output logic [3:0] o_wr_addr,
    output logic [23:0] o_wr_data,
    output logic [1:0] o_wr_nbytes,
    output logic o_rd_req,
    output logic [3:0] o_rd_addr,
    output logic o_timeout,
    output logic o_busy
);
    typedef enum logic [2:0] {D_IDLE, D_INSTR, D_RX, D_TURN, D_TX} dspt_dev_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: sclk, cs_n, sdio
    logic [2:0] raw;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic [2:0] lvl_prev;
    assign raw = {link.sclk, link.cs_n, link.sdio};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            // level changes once second and third stage agree
            always_ff @(posedge i_mclk)
            begin
                if (i_srst)
                begin
                    s1[g] <= dspt_pkg::DEV_SYNC_RST[g];
                    s2[g] <= dspt_pkg::DEV_SYNC_RST[g];
                    s3[g] <= dspt_pkg::DEV_SYNC_RST[g];
                    lvl[g] <= dspt_pkg::DEV_SYNC_RST[g];
                    lvl_prev[g] <= dspt_pkg::DEV_SYNC_RST[g];
                end
                else
                begin
                    s1[g] <= raw[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g])
                        lvl[g] <= s3[g];
                    lvl_prev[g] <= lvl[g];
                end
            end
        end
    endgenerate

    logic fall;
    logic edge_seen;
    logic cs_act;
    logic din;
    assign fall = lvl_prev[2] & ~lvl[2];
    assign edge_seen = lvl_prev[2] ^ lvl[2];
    assign cs_act = ~lvl[1];
    assign din = lvl[0];

    ////////////////////////////////////////////////////////////////////////////////
    // transfer engine
    dspt_dev_state_e state;
    logic [4:0] bit_cnt;
    logic [4:0] nbits;
    logic [23:0] shreg;
    logic [23:0] next_sh;
    logic [7:0] next_ins;
    logic [3:0] wait_cnt;
    logic [13:0] stall_cnt;
    logic stall;
    assign next_sh = {shreg[22:0], din};
    assign next_ins = next_sh[7:0];
    assign stall = (state != D_IDLE) && (stall_cnt == 14'(STALL_CYC - 1));
    assign o_busy = (state != D_IDLE);

    // stall watchdog, restarted by every sclk edge
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || state == D_IDLE || edge_seen)
            stall_cnt <= 14'h0;
        else
            stall_cnt <= stall_cnt + 14'h1;
    end

    // state, shift register and data pin
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            state <= D_IDLE;
            bit_cnt <= 5'h0;
            nbits <= 5'h8;
            shreg <= 24'h0;
            wait_cnt <= 4'h0;
            link.dev_sdio_o <= 1'b1;
            link.dev_sdio_oe <= 1'b0;
        end
        // R16 stall reset
        else if (stall)
        begin
            state <= D_IDLE;
            bit_cnt <= 5'h0;
            link.dev_sdio_oe <= 1'b0;
        end
        else
        begin
            case (state)
                D_IDLE:
                begin
                    // R7 sample on fall
                    if (fall && cs_act)
                    begin
                        shreg <= next_sh;
                        bit_cnt <= 5'h1;
                        state <= D_INSTR;
                    end
                end
                D_INSTR:
                begin
                    if (!cs_act)
                        state <= D_IDLE;
                    else if (fall)
                    begin
                        shreg <= next_sh;
                        bit_cnt <= bit_cnt + 5'h1;
                        // R17 decode instruction
                        if (bit_cnt == 5'h7)
                        begin
                            nbits <= {next_ins[dspt_pkg::INSTR_CNT_MSB:dspt_pkg::INSTR_CNT_LSB]
                                + 2'h1, 3'h0};
                            bit_cnt <= 5'h0;
                            wait_cnt <= 4'h0;
                            state <= next_ins[dspt_pkg::INSTR_RW_BIT] ? D_TURN : D_RX;
                        end
                    end
                end
                D_RX:
                begin
                    if (!cs_act)
                        state <= D_IDLE;
                    else if (fall)
                    begin
                        shreg <= next_sh;
                        bit_cnt <= bit_cnt + 5'h1;
                        if (bit_cnt == nbits - 5'h1)
                            state <= D_IDLE;
                    end
                end
                D_TURN:
                begin
                    // R12 line left free
                    wait_cnt <= wait_cnt + 4'h1;
                    if (!cs_act)
                        state <= D_IDLE;
                    // R11 early drive
                    else if (wait_cnt == 4'(dspt_pkg::DEV_TURN_WAIT - 1))
                    begin
                        shreg <= {i_rd_data[22:0], 1'b0};
                        link.dev_sdio_o <= i_rd_data[23];
                        link.dev_sdio_oe <= 1'b1;
                        state <= D_TX;
                    end
                end
                D_TX:
                begin
                    // R2 ignores chip select; R8 shift after hold
                    if (fall)
                    begin
                        bit_cnt <= bit_cnt + 5'h1;
                        link.dev_sdio_o <= shreg[23];
                        shreg <= {shreg[22:0], 1'b0};
                        // R13 release after data; R1 tri-state
                        if (bit_cnt == nbits - 5'h1)
                        begin
                            link.dev_sdio_oe <= 1'b0;
                            state <= D_IDLE;
                        end
                    end
                end
                default:
                    state <= D_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // user side strobes
    logic instr_done;
    logic wr_done;
    assign instr_done = (state == D_INSTR) && cs_act && fall && (bit_cnt == 5'h7);
    assign wr_done = (state == D_RX) && cs_act && fall && (bit_cnt == nbits - 5'h1);

    // write strobe with left-justified data
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_wr_valid <= 1'b0;
            o_wr_data <= 24'h0;
        end
        else
        begin
            o_wr_valid <= wr_done && !stall;
            if (wr_done && !stall)
                o_wr_data <= next_sh << (5'h18 - nbits);
        end
    end

    // decoded address, count, read request and stall flag
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_wr_addr <= 4'h0;
            o_rd_addr <= 4'h0;
            o_wr_nbytes <= 2'h0;
            o_rd_req <= 1'b0;
            o_timeout <= 1'b0;
        end
        else
        begin
            o_rd_req <= instr_done && !stall && next_ins[dspt_pkg::INSTR_RW_BIT];
            o_timeout <= stall;
            if (instr_done && !stall)
            begin
                o_wr_addr <= next_ins[dspt_pkg::INSTR_ADDR_MSB:0];
                o_rd_addr <= next_ins[dspt_pkg::INSTR_ADDR_MSB:0];
                o_wr_nbytes <= next_ins[dspt_pkg::INSTR_CNT_MSB:dspt_pkg::INSTR_CNT_LSB];
            end
        end
    end
endmodule // dspt_device

/* File: design/dspt_host.sv */
`timescale 1ns/1ps
module dspt_host (
    input wire logic i_mclk,
    input wire logic i_srst,
    dspt_link_if.host link,
    input wire logic i_start,
    input wire logic i_rw,
    input wire logic [3:0] i_addr,
    input wire logic [1:0] i_nbytes,
    input wire logic [23:0] i_wdata,
    input wire logic i_use_cs,
    output logic o_busy,
    output logic o_done,
    output logic [23:0] o_rdata
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_CSWAIT,
        H_INSTR,
        H_GAP,
        H_DATA,
        H_TAIL
    } dspt_host_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // data line synchroniser
    logic s1;
    logic s2;
    logic s3;
    logic din;

    // level changes once second and third stage agree
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            din <= 1'b1;
        end
        else
        begin
            s1 <= link.sdio;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                din <= s3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit timing: one bit is SCLK_BIT_CYC cycles, clock high first half
    dspt_host_state_e state;
    logic [3:0] phase;
    logic [4:0] bit_cnt;
    logic [4:0] nbits;
    logic [5:0] wait_cnt;
    logic [5:0] tail_len;
    logic rd;
    logic cs_mode;
    logic [31:0] tx;
    logic [23:0] rx;
    logic shifting;
    logic bit_end;
    logic last_instr;
    logic last_data;

    assign shifting = (state == H_INSTR) || (state == H_DATA);
    assign bit_end = shifting && (phase == 4'(dspt_pkg::SCLK_BIT_CYC - 1));
    assign last_instr = (state == H_INSTR) && bit_end && (bit_cnt == 5'h7);
    assign last_data = (state == H_DATA) && bit_end && (bit_cnt == nbits - 5'h1);
    assign o_busy = (state != H_IDLE);

    // phase counter inside each bit
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !shifting || bit_end)
            phase <= 4'h0;
        else
            phase <= phase + 4'h1;
    end

    // R4 host paces clock; R5 R6 clock divider
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            link.sclk <= 1'b0;
        else if (shifting && phase == 4'h0)
            link.sclk <= 1'b1;
        else if (shifting && phase == 4'(dspt_pkg::SCLK_HALF_CYC))
            link.sclk <= 1'b0;
    end

    // transfer sequencing and spacing waits
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            state <= H_IDLE;
            bit_cnt <= 5'h0;
            nbits <= 5'h8;
            wait_cnt <= 6'h0;
            tail_len <= 6'h0;
            rd <= 1'b0;
            cs_mode <= 1'b0;
        end
        else
        begin
            case (state)
                H_IDLE:
                begin
                    wait_cnt <= 6'h0;
                    bit_cnt <= 5'h0;
                    if (i_start)
                    begin
                        rd <= i_rw;
                        cs_mode <= i_use_cs;
                        nbits <= {i_nbytes + 2'h1, 3'h0};
                        state <= i_use_cs ? H_CSWAIT : H_INSTR;
                    end
                end
                H_CSWAIT:
                begin
                    // R10 select setup
                    wait_cnt <= wait_cnt + 6'h1;
                    if (wait_cnt == 6'(dspt_pkg::CS_SETUP_CYC - 1))
                        state <= H_INSTR;
                end
                H_INSTR:
                begin
                    if (bit_end)
                        bit_cnt <= bit_cnt + 5'h1;
                    if (last_instr)
                    begin
                        bit_cnt <= 5'h0;
                        wait_cnt <= 6'h0;
                        state <= H_GAP;
                    end
                end
                H_GAP:
                begin
                    // R9 instruction to data gap
                    wait_cnt <= wait_cnt + 6'h1;
                    if (wait_cnt == 6'(dspt_pkg::INSTR_GAP_CYC - dspt_pkg::SCLK_HALF_CYC))
                        state <= H_DATA;
                end
                H_DATA:
                begin
                    if (bit_end)
                        bit_cnt <= bit_cnt + 5'h1;
                    if (last_data)
                    begin
                        wait_cnt <= 6'h0;
                        // R14 R15 spacing before next
                        tail_len <= cs_mode ? 6'(dspt_pkg::CS_HIGH_CYC)
                            : 6'(dspt_pkg::XFER_GAP_CYC - dspt_pkg::SCLK_HALF_CYC + 1);
                        state <= H_TAIL;
                    end
                end
                H_TAIL:
                begin
                    wait_cnt <= wait_cnt + 6'h1;
                    if (wait_cnt == tail_len)
                        state <= H_IDLE;
                end
                default:
                    state <= H_IDLE;
            endcase
        end
    end

    // R3 chip select per transfer, else held low
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            link.cs_n <= 1'b1;
        else if (state == H_IDLE)
            link.cs_n <= ~(i_start && i_use_cs) & i_use_cs;
        else if (state == H_TAIL)
            link.cs_n <= cs_mode;
    end

    // R17 instruction then write data, msb first
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            tx <= 32'h0;
            link.host_sdio_o <= 1'b1;
            link.host_sdio_oe <= 1'b0;
        end
        else if (state == H_IDLE)
        begin
            if (i_start)
                tx <= {i_rw, i_nbytes, 1'b0, i_addr, i_wdata};
            link.host_sdio_oe <= 1'b0;
        end
        else if (shifting && phase == 4'h0)
        begin
            link.host_sdio_o <= tx[31];
            link.host_sdio_oe <= (state == H_INSTR) || !rd;
            tx <= {tx[30:0], 1'b0};
        end
        // R12 release for read turnaround
        else if (last_instr || last_data)
        begin
            link.host_sdio_oe <= 1'b0;
        end
    end

    // read data capture after own falling edge
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            rx <= 24'h0;
        else if (state == H_IDLE)
            rx <= 24'h0;
        else if (state == H_DATA && rd && phase == 4'(dspt_pkg::HOST_SAMPLE_PH))
            rx <= {rx[22:0], din};
    end

    // completion strobe and left-justified read result
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_done <= 1'b0;
            o_rdata <= 24'h0;
        end
        else
        begin
            o_done <= last_data;
            if (last_data && rd)
                o_rdata <= rx << (5'h18 - nbits);
        end
    end
endmodule // dspt_host

/* File: design/dspt_link_if.sv */
`timescale 1ns/1ps
// serial link: clock, chip select, one shared data line
interface dspt_link_if;
    logic sclk;
    logic cs_n;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic sdio;
    // resolved line level, idle line pulled high
    assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
    modport dev (input sclk, input cs_n, input sdio, output dev_sdio_o, output dev_sdio_oe);
    modport host (output sclk, output cs_n, input sdio, output host_sdio_o,
        output host_sdio_oe);
endinterface

/* File: design/dspt_pkg.sv */
// Functional notes
// R1: device data pin tri-stated except while transmitting
// R2: chip select high never tri-states active output
// R3: shared bus needs chip select, else tie low
// R4: host paces serial clock; device follows its edges
// R5: serial clock at most master clock over ten
// R6: each clock phase lasts five master periods
// R7: device samples input bits on clock falling edge
// R8: output bit valid at fall, held four periods
// R9: thirteen periods from instruction end to data
// R10: chip select low eleven periods before clocking
// R11: device drives read data four periods early
// R12: line released six to eight periods after instruction
// R13: device releases pin four to six periods after data
// R14: tied chip select: forty-one periods between transfers
// R15: chip select high twenty-two periods between assertions
// R16: stalled clock resets serial port; host restarts
// R17: instruction byte then data bytes, msb first
package dspt_pkg;
    // master_clock_input period equals the block clock period
    localparam int CLK_PERIOD_NS = 8;
    localparam int MCLK_PERIOD_NS = 8;
    // figures below are in master clock periods, except STALL_DATA_PERIODS, which counts data periods
    localparam int SCLK_DIV_MCLK = 10;
    localparam int SCLK_HALF_MCLK = 5;
    localparam int DOUT_HOLD_MCLK = 4;
    localparam int INSTR_GAP_MCLK = 13;
    localparam int CS_SETUP_MCLK = 11;
    localparam int TURN_LEAD_MCLK = 4;
    localparam int TURN_REL_MAX_MCLK = 8;
    localparam int DATA_REL_MIN_MCLK = 4;
    localparam int XFER_GAP_MCLK = 41;
    localparam int CS_HIGH_MCLK = 22;
    localparam int DATA_PERIOD_MCLK = 2048;
    localparam int STALL_DATA_PERIODS = 4;
    // cycle counts derived from the figures (least times round up)
    localparam int SCLK_HALF_CYC = (SCLK_HALF_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int SCLK_BIT_CYC = (SCLK_DIV_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int INSTR_GAP_CYC = (INSTR_GAP_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CS_SETUP_CYC = (CS_SETUP_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int TURN_LEAD_CYC = (TURN_LEAD_MCLK * MCLK_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int XFER_GAP_CYC = (XFER_GAP_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CS_HIGH_CYC = (CS_HIGH_MCLK * MCLK_PERIOD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int STALL_CYC = STALL_DATA_PERIODS * DATA_PERIOD_MCLK * MCLK_PERIOD_NS
        / CLK_PERIOD_NS;
    // input synchroniser: edge seen this many cycles after the pin
    localparam int SYNC_LAT_CYC = 4;
    localparam int DEV_TURN_WAIT = INSTR_GAP_CYC - TURN_LEAD_CYC - SYNC_LAT_CYC;
    localparam int HOST_SAMPLE_PH = SCLK_HALF_CYC + SYNC_LAT_CYC - 1;
    // instruction byte layout
    localparam int INSTR_RW_BIT = 7;
    localparam int INSTR_CNT_MSB = 6;
    localparam int INSTR_CNT_LSB = 5;
    localparam int INSTR_ADDR_MSB = 3;
    localparam int DATA_BITS = 24;
    localparam logic [2:0] DEV_SYNC_RST = 3'h3;
endpackage

/* File: test/dspt_link_chk.sv */
`timescale 1ns/1ps
// watches the shared serial link between host and device ends
module dspt_link_chk (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe,
    input wire logic host_sdio_o,
    input wire logic host_sdio_oe,
    input wire logic sdio
);
    logic [7:0] cs_high_cnt;
    logic [7:0] low_cnt;
    logic sclk_d;
    logic gap_par;
    logic sel_gap;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////
    // cycles spent with chip select high, saturating
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            cs_high_cnt <= 8'hff;
        else if (!cs_n)
            cs_high_cnt <= 8'h00;
        else if (cs_high_cnt != 8'hff)
            cs_high_cnt <= cs_high_cnt + 8'h01;
    end
    // cycles spent with serial clock low, saturating
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            low_cnt <= 8'hff;
        else if (sclk)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hff)
            low_cnt <= low_cnt + 8'h01;
    end
    // long gaps alternate: before instruction, then before data; select high marks a gap
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            sclk_d <= 1'b0;
            gap_par <= 1'b0;
            sel_gap <= 1'b1;
        end
        else
        begin
            sclk_d <= sclk;
            if (sclk && !sclk_d && low_cnt > 8'h05)
                gap_par <= ~gap_par;
            if (sclk && !sclk_d)
                sel_gap <= 1'b0;
            else if (cs_n)
                sel_gap <= 1'b1;
        end
    end
    ////////////////////////////////////////
    sequence s_last_fall;
        $fell(sclk) ##1 !sclk [*6];
    endsequence
    sequence s_lead;
        !sclk [*2] ##[1:3] $rose(sclk);
    endsequence
    a_line_exclusive: assert property (!(dev_sdio_oe && host_sdio_oe))
        else $error("both ends drive the data line");
    a_turn_gap: assert property ($fell(host_sdio_oe) |-> !dev_sdio_oe [*5])
        else $error("device drove line during turnaround");
    a_out_hold: assert property ($fell(sclk) && dev_sdio_oe |=>
        (dev_sdio_oe && $stable(dev_sdio_o)) [*3])
        else $error("device output bit not held after falling edge");
    a_release_time: assert property (s_last_fall |-> !dev_sdio_oe)
        else $error("device kept driving after last data edge");
    a_drive_lead: assert property ($rose(dev_sdio_oe) |-> s_lead)
        else $error("device drive not ahead of first data edge");
    a_cs_setup: assert property ($fell(cs_n) |-> !sclk [*8] ##1 !sclk [*3])
        else $error("serial clock rose too soon after select");
    a_cs_gap: assert property ($fell(cs_n) |-> cs_high_cnt >= 8'h16)
        else $error("chip select high time too short");
    a_phase_min: assert property ($changed(sclk) |=> $stable(sclk) [*4])
        else $error("serial clock phase too short");
    a_instr_gap: assert property ($rose(sclk) |->
        (low_cnt == 8'h05 || low_cnt >= 8'h0d))
        else $error("gap before data byte too short");
    a_xfer_gap: assert property ($rose(sclk) && low_cnt > 8'h05 && !gap_par && !sel_gap |->
        low_cnt >= 8'h29)
        else $error("transfer gap too short with select tied low");
endmodule // dspt_link_chk

/* File: test/testbench.sv */
`timescale 1ns/1ps
// host end and device end face each other; a second device meets a stalling driver
module testbench;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_start = 1'b0;
    logic i_rw = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [1:0] i_nbytes = 2'h0;
    logic [23:0] i_wdata = 24'h0;
    logic i_use_cs = 1'b0;
    logic [23:0] i_rd_data = 24'h0;
    logic h_busy, h_done, d_wr_valid, d_rd_req, d_busy, s_timeout, s_busy;
    logic [23:0] h_rdata, d_wr_data, wr_data_cap;
    logic [3:0] d_wr_addr, d_rd_addr, wr_addr_cap, rd_addr_cap;
    logic [1:0] d_wr_nbytes, wr_nb_cap;
    logic t_sclk = 1'b0;
    logic t_cs_n = 1'b1;
    logic prev_sclk = 1'b0;
    logic [31:0] wire_bits = 32'h0;
    logic [31:0] seed = 32'h0001662e;
    int err_total = 0;
    int compares = 0;
    int wr_seen = 0;
    int n;
    int exp_q[$];
    dspt_link_if link();
    dspt_link_if link_b();
    // stalling driver on the second link
    assign link_b.sclk = t_sclk;
    assign link_b.cs_n = t_cs_n;
    assign link_b.host_sdio_o = 1'b1;
    assign link_b.host_sdio_oe = 1'b0;
    always #4 i_mclk = ~i_mclk;
    dspt_host dspt_host_inst (.i_mclk(i_mclk), .i_srst(i_srst), .link(link.host),
        .i_start(i_start), .i_rw(i_rw), .i_addr(i_addr), .i_nbytes(i_nbytes),
        .i_wdata(i_wdata), .i_use_cs(i_use_cs), .o_busy(h_busy), .o_done(h_done),
        .o_rdata(h_rdata));
    dspt_device #(.STALL_CYC(200)) dspt_device_inst (.i_mclk(i_mclk), .i_srst(i_srst),
        .link(link.dev), .i_rd_data(i_rd_data), .o_wr_valid(d_wr_valid),
        .o_wr_addr(d_wr_addr), .o_wr_data(d_wr_data), .o_wr_nbytes(d_wr_nbytes),
        .o_rd_req(d_rd_req), .o_rd_addr(d_rd_addr), .o_timeout(), .o_busy(d_busy));
    dspt_device #(.STALL_CYC(200)) dspt_device_inst2 (.i_mclk(i_mclk), .i_srst(i_srst),
        .link(link_b.dev), .i_rd_data(24'h0), .o_wr_valid(), .o_wr_addr(), .o_wr_data(),
        .o_wr_nbytes(), .o_rd_req(), .o_rd_addr(), .o_timeout(s_timeout), .o_busy(s_busy));
    dspt_link_chk dspt_link_chk_inst (.i_mclk(i_mclk), .i_srst(i_srst), .sclk(link.sclk),
        .cs_n(link.cs_n), .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe),
        .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe), .sdio(link.sdio));
    ////////////////////////////////////////
    // wire bits at each clock fall, plus device strobes, seen where settled
    always @(negedge i_mclk)
    begin
        prev_sclk <= link.sclk;
        if (prev_sclk && !link.sclk)
            wire_bits <= {wire_bits[30:0], link.sdio};
        if (d_wr_valid === 1'b1)
        begin
            wr_seen <= wr_seen + 1;
            wr_data_cap <= d_wr_data;
            wr_addr_cap <= d_wr_addr;
            wr_nb_cap <= d_wr_nbytes;
        end
        if (d_rd_req === 1'b1)
            rd_addr_cap <= d_rd_addr;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // bounded wait for a flag to reach a level
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        n = 0;
        while (sig !== lvl && n < lim)
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (sig !== lvl)
        begin
            err_total++;
            summarize();
        end
    endtask
    // one host transfer, then device side and wire compared with the model
    task automatic xfer(input logic rw, input logic [1:0] nb, input logic cs);
        logic [31:0] mask;
        logic [23:0] dmask;
        int wr_before;
        @(posedge i_mclk);
        #1;
        seed = lfsr(seed);
        i_rw = rw;
        i_nbytes = nb;
        i_use_cs = cs;
        i_addr = seed[3:0];
        i_wdata = seed[27:4];
        seed = lfsr(seed);
        i_rd_data = seed[23:0];
        i_start = 1'b1;
        mask = 32'hffffffff >> (8 * (2 - int'(nb)));
        dmask = 24'hffffff << (8 * (2 - int'(nb)));
        exp_q.push_back(int'({rw, nb, 1'b0, i_addr, rw ? i_rd_data : i_wdata} >>
            (8 * (2 - int'(nb)))));
        wr_before = wr_seen;
        @(posedge i_mclk);
        #1;
        i_start = 1'b0;
        wait_for(h_done, 1'b1, 3000);
        wait_for(h_busy, 1'b0, 200);
        check(wire_bits & mask, exp_q.pop_front());
        check(wr_seen - wr_before, {31'h0, !rw});
        check({d_busy, link.dev_sdio_oe}, 2'h0);
        if (rw)
        begin
            check(h_rdata, i_rd_data & dmask);
            check(rd_addr_cap, i_addr);
        end
        else
        begin
            check(wr_data_cap, i_wdata & dmask);
            check({wr_nb_cap, wr_addr_cap}, {nb, i_addr});
        end
    endtask
    ////////////////////////////////////////
    // reset, every direction, length and select mode, then a stalled transfer
    initial
    begin
        repeat (8) @(posedge i_mclk);
        #1;
        i_srst = 1'b0;
        repeat (4) @(posedge i_mclk);
        for (int i = 0; i < 12; i++)
        begin
            xfer(i[0], 2'(i / 2 % 3), i >= 6);
            $display("test %0d done", i);
        end
        t_cs_n = 1'b0;
        #99;
        repeat (3)
        begin
            #32 t_sclk = 1'b1;
            #32 t_sclk = 1'b0;
        end
        wait_for(s_timeout, 1'b1, 400);
        check(32'(n >= 190 && n <= 215), 32'h1);
        @(posedge i_mclk);
        #1;
        check({s_busy, link_b.dev_sdio_oe}, 2'h0);
        t_cs_n = 1'b1;
        $display("test stall done");
        summarize();
    end
endmodule // testbench
